// file: verilog/rsf_reset_sync_filter.sv
// Reset synchroniser with clock-lock glitch filter and optional scan reset muxing.
`timescale 1ns/100ps
`default_nettype none
`include "rsf_map.svh"

module rsf_reset_sync_filter #(
	parameter bit ACT_HIGH = `RSF_OPT_OFF,
	parameter bit SYNC_CLEAR = `RSF_OPT_OFF,
	parameter bit SCAN_EN = `RSF_OPT_OFF,
	parameter int SHIFT_LEN = `RSF_SHIFT_LEN,
	parameter int TOP_TAPS = `RSF_TOP_TAPS
) (
	// Clock, module reset and clock enable.
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Reset request and clock generator lock.
	input wire logic reset_request_in,
	input wire logic clock_lock,
	// Scan test controls.
	input wire logic scan_reset_n,
	input wire logic scan_mode_sel,
	// Reset outputs to the system.
	output logic filtered_reset_n,
	output logic unfiltered_reset_n,
	output rsf_pkg::rsf_rst_src_type reset_source
);
	import rsf_pkg::*;

	// =============================================================
	// Module reset release
	logic rst_sync_n;

	rsf_release_sync #(
		.STAGES(`RSF_RELEASE_STAGES)
	) u_release (
		.mclk(mclk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.sync_reset_n(rst_sync_n)
	);

	// =============================================================
	// Request polarity and register reset source
	logic req_inactive;
	logic arst_n;
	logic scan_active;

	// Normalise the request; the raw path bypasses every clock.
	assign req_inactive = ACT_HIGH ? !reset_request_in : reset_request_in;
	assign unfiltered_reset_n = req_inactive;

	// Scan muxing only exists with asynchronous clears; otherwise scan pins are dead.
	assign scan_active = SCAN_EN && !SYNC_CLEAR && scan_mode_sel;
	assign reset_source = scan_active ? RSF_SRC_SCAN : RSF_SRC_NORMAL;
	assign arst_n = (reset_source == RSF_SRC_SCAN) ? scan_reset_n : (req_inactive && rst_sync_n);

	// =============================================================
	// Lock shift register and output register
	logic [SHIFT_LEN-1:0] shift_r;
	logic [SHIFT_LEN-1:0] shift_nxt;
	logic out_r;
	logic out_nxt;
	logic top_all;
	logic sync_clear;

	// All upper taps must agree, so a single-cycle lock glitch never releases reset.
	assign top_all = &shift_r[SHIFT_LEN-1:SHIFT_LEN-TOP_TAPS];
	assign sync_clear = SYNC_CLEAR && !(req_inactive && rst_sync_n);

	// Next values; the clear in sync mode is taken on the clock.
	always_comb begin
		shift_nxt = shift_r;
		out_nxt = out_r;
		if (clk_en) begin
			shift_nxt = {shift_r[SHIFT_LEN-2:0], clock_lock};
			out_nxt = top_all ? `RSF_OUT_RELEASE : `RSF_OUT_CLEAR;
			if (sync_clear) begin
				shift_nxt = `RSF_SHIFT_CLEAR;
			end
		end
	end

	generate
		if (SYNC_CLEAR) begin : g_sync
			// Shift register is cleared through its data path only.
			always_ff @(posedge mclk) begin
				shift_r <= shift_nxt;
			end
			// Output register has no reset; the output gate covers its power-up value.
			always_ff @(posedge mclk) begin
				out_r <= out_nxt;
			end

			// =============================================================
			// Synchronous clear checks
			// The clear is only taken on an enabled edge, so a frozen block keeps its history.
			sync_clear_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
				clk_en && sync_clear |=> shift_r == `RSF_SHIFT_CLEAR)
				else $error("Shift register not cleared on the clock.");
			// Scan pins must never steer the clear source in this mode.
			scan_unused_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
				reset_source == RSF_SRC_NORMAL)
				else $error("Scan source selected with synchronous clear.");
		end else begin : g_async
			// Both registers share the muxed asynchronous clear.
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					shift_r <= `RSF_SHIFT_CLEAR;
					out_r <= `RSF_OUT_CLEAR;
				end else begin
					shift_r <= shift_nxt;
					out_r <= out_nxt;
				end
			end

			// =============================================================
			// Asynchronous clear checks
			async_clear_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
				!arst_n |-> (out_r == `RSF_OUT_CLEAR) && (shift_r == `RSF_SHIFT_CLEAR))
				else $error("Filter registers not cleared by asynchronous reset.");
			scan_select_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
				(SCAN_EN && scan_mode_sel && !scan_reset_n) |-> !out_r && !filtered_reset_n)
				else $error("Scan reset did not clear the output register.");
		end
	endgenerate

	// =============================================================
	// Filtered reset output
	// The request term is combinational so assertion never waits for a clock edge.
	assign filtered_reset_n = out_r && req_inactive && rst_sync_n;

	// =============================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_sync_n);

	sequence lock_steady_s;
		(clk_en && clock_lock && req_inactive && !scan_active) [*6];
	endsequence

	sequence lock_lost_s;
		(clk_en && !clock_lock) [*4];
	endsequence

	sequence frozen_s;
		!clk_en && arst_n && !sync_clear ##1 arst_n;
	endsequence

	// An active request, whatever its input polarity.
	sequence request_active_s;
		!req_inactive;
	endsequence

	// Scan mode with its test reset pulled low.
	sequence scan_clear_s;
		scan_active && !scan_reset_n;
	endsequence

	// =============================================================
	// Routing and polarity checks
	// These guard the muxing, which tests reach only in a few parameter sets.
	raw_polarity_a: assert property (request_active_s |-> !unfiltered_reset_n)
		else $error("Unfiltered reset high while request is active.");
	scan_route_a: assert property (scan_active |-> (arst_n == scan_reset_n))
		else $error("Scan reset not routed to the register clear.");
	normal_route_a: assert property (!scan_active |-> (reset_source == RSF_SRC_NORMAL))
		else $error("Normal reset source not selected outside scan mode.");
	scan_clear_a: assert property (scan_clear_s |-> !filtered_reset_n)
		else $error("Filtered reset high during scan reset.");
	release_gate_a: assert property (filtered_reset_n |-> out_r && req_inactive)
		else $error("Filtered reset high without register and request.");

	// =============================================================
	// Filter timing checks

	raw_follow_a: assert property (unfiltered_reset_n == (ACT_HIGH ? !reset_request_in : reset_request_in))
		else $error("Unfiltered reset does not follow the request.");
	request_gate_a: assert property (!req_inactive |-> !filtered_reset_n)
		else $error("Filtered reset high while request is active.");
	shift_entry_a: assert property (clk_en && !sync_clear && arst_n ##1 arst_n |-> shift_r[0] == $past(clock_lock))
		else $error("Lock sample not shifted into stage zero.");
	out_load_a: assert property (clk_en && arst_n ##1 arst_n |-> out_r == $past(top_all))
		else $error("Output register not loaded from upper taps.");
	lock_release_a: assert property (lock_steady_s |=> (filtered_reset_n || !req_inactive))
		else $error("Filtered reset not released six cycles after lock.");
	lock_drop_a: assert property (lock_lost_s |=> !filtered_reset_n)
		else $error("Filtered reset not asserted after lock loss.");
	release_sync_a: assert property ($rose(filtered_reset_n) |-> $rose(out_r) || $rose(req_inactive))
		else $error("Filtered reset released without a clocked cause.");
	freeze_a: assert property (frozen_s |-> $stable(shift_r) && $stable(out_r))
		else $error("State changed while clock enable low.");

endmodule
`default_nettype wire

// file: verilog/rsf_map.svh
// Named constants for the reset synchroniser and glitch filter.
`ifndef RSF_MAP_SVH
`define RSF_MAP_SVH

// =============================================================
// Filter geometry
`define RSF_SHIFT_LEN 5
`define RSF_TOP_TAPS 3
`define RSF_RELEASE_STAGES 2

// =============================================================
// Reset and option values
`define RSF_SHIFT_CLEAR 5'h00
`define RSF_OUT_CLEAR 1'h0
`define RSF_OUT_RELEASE 1'h1
`define RSF_OPT_OFF 1'h0
`define RSF_OPT_ON 1'h1

`endif

// file: verilog/rsf_pkg.sv
// Types shared by the reset synchroniser and glitch filter.
package rsf_pkg;

	// =============================================================
	// Source of the filter registers' asynchronous clear.
	typedef enum logic [1:0] {
		RSF_SRC_NORMAL = 2'b01,
		RSF_SRC_SCAN = 2'b10
	} rsf_rst_src_type;

endpackage

// file: verilog/rsf_release_sync.sv
// Two-flop release synchroniser for the module reset.
`timescale 1ns/100ps
`default_nettype none
`include "rsf_map.svh"

module rsf_release_sync #(
	parameter int STAGES = `RSF_RELEASE_STAGES
) (
	// Clock, enable and raw reset.
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Released reset.
	output logic sync_reset_n
);
	import rsf_pkg::*;

	logic [STAGES-1:0] stage_r;
	logic [STAGES-1:0] stage_nxt;

	// Shift ones in; assertion is immediate, release waits for the chain.
	always_comb begin
		stage_nxt = stage_r;
		if (clk_en) begin
			stage_nxt = {stage_r[STAGES-2:0], 1'h1};
		end
	end

	// Only the last stage is read outside, so the first never feeds logic.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stage_r <= '0;
		end else begin
			stage_r <= stage_nxt;
		end
	end

	assign sync_reset_n = stage_r[STAGES-1];

endmodule
`default_nettype wire

// file: verification/rsf_lock_model.sv
// Behavioural clock generator whose lock output feeds the reset filter.
`timescale 1ns/100ps
`default_nettype none

// =============================================================
// Lock model
module rsf_lock_model (
	// Clock and run request.
	input wire logic mclk,
	input wire logic pll_run,
	// Lock indication.
	output logic clock_lock
);
	// Lock trails the run request by one edge; no settling delay is modelled, so glitches pass.
	always_ff @(posedge mclk) begin
		clock_lock <= pll_run;
	end
endmodule

`default_nettype wire

// file: verification/tb_rsf_reset_sync_filter.sv
// Self-checking bench for the reset synchroniser and glitch filter.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t got %0h want %0h", $time, a, b); end end

// =============================================================
// Bench top
module tb_rsf_reset_sync_filter;
	import rsf_pkg::*;
	logic mclk = 1'h0;
	logic reset_n = 1'h0;
	logic clk_en = 1'h1;
	logic reset_request_in = 1'h1;
	logic pll_run = 1'h0;
	logic scan_reset_n = 1'h1;
	logic scan_mode_sel = 1'h0;
	logic clock_lock;
	logic filtered_reset_n;
	logic unfiltered_reset_n;
	rsf_rst_src_type reset_source;
	logic req_high;
	logic filt_scan;
	logic raw_scan;
	rsf_rst_src_type src_scan;
	logic filt_sync;
	logic raw_sync;
	rsf_rst_src_type src_sync;
	int checks = 0;
	int miscompares = 0;
	int cycles = 0;
	int n;

	// A 40 MHz clock.
	always #12.5 mclk = ~mclk;

	rsf_lock_model u_lock (.mclk(mclk), .pll_run(pll_run), .clock_lock(clock_lock));
	rsf_reset_sync_filter u_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
		.reset_request_in(reset_request_in), .clock_lock(clock_lock), .scan_reset_n(scan_reset_n),
		.scan_mode_sel(scan_mode_sel), .filtered_reset_n(filtered_reset_n),
		.unfiltered_reset_n(unfiltered_reset_n), .reset_source(reset_source));

	// Active-high request with scan muxing, and a synchronous-clear copy.
	assign req_high = !reset_request_in;
	rsf_reset_sync_filter #(.ACT_HIGH(1'h1), .SCAN_EN(1'h1)) u_dut_scan (.mclk(mclk), .reset_n(reset_n),
		.clk_en(clk_en), .reset_request_in(req_high), .clock_lock(clock_lock), .scan_reset_n(scan_reset_n),
		.scan_mode_sel(scan_mode_sel), .filtered_reset_n(filt_scan), .unfiltered_reset_n(raw_scan),
		.reset_source(src_scan));
	rsf_reset_sync_filter #(.SYNC_CLEAR(1'h1), .SCAN_EN(1'h1)) u_dut_sync (.mclk(mclk), .reset_n(reset_n),
		.clk_en(clk_en), .reset_request_in(reset_request_in), .clock_lock(clock_lock),
		.scan_reset_n(scan_reset_n), .scan_mode_sel(scan_mode_sel), .filtered_reset_n(filt_sync),
		.unfiltered_reset_n(raw_sync), .reset_source(src_sync));

	// Hang guard: the whole run needs well under a hundred cycles.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			stop_test();
		end
	end

	// Counts edges until the filtered reset reaches a level, bounded so a stuck output ends the wait.
	task automatic edges_to(input logic lvl, output int cnt);
		cnt = 0;
		while (filtered_reset_n !== lvl && cnt < 40) begin
			@(posedge mclk);
			#1;
			cnt++;
		end
	endtask

	// Lock rises: one model edge, then six sampling edges.
	task automatic lock_release();
		@(posedge mclk);
		pll_run <= 1'h1;
		edges_to(1'h1, n);
		`CHK(n, 7)
		`CHK(filt_sync, 1'h1)
	endtask

	// A two-cycle lock pulse must never release the reset.
	task automatic lock_glitch();
		@(posedge mclk);
		pll_run <= 1'h1;
		repeat (2) @(posedge mclk);
		pll_run <= 1'h0;
		repeat (12) @(posedge mclk);
		#1;
		`CHK(filtered_reset_n, 1'h0)
		`CHK(filt_sync, 1'h0)
	endtask

	// Frozen clock enable holds the output; lock loss then shows after four enabled edges.
	task automatic lock_drop();
		@(posedge mclk);
		clk_en <= 1'h0;
		pll_run <= 1'h0;
		repeat (8) @(posedge mclk);
		#1;
		`CHK(filtered_reset_n, 1'h1)
		@(posedge mclk);
		clk_en <= 1'h1;
		edges_to(1'h0, n);
		`CHK(n, 4)
	endtask

	// Request drops both outputs at once; release restarts the full walk, but the sync copy's filtered output is high again at once.
	task automatic request_pulse();
		@(posedge mclk);
		reset_request_in <= 1'h0;
		#1;
		`CHK(filtered_reset_n, 1'h0)
		`CHK(unfiltered_reset_n, 1'h0)
		`CHK(filt_sync, 1'h0)
		`CHK(filt_scan, 1'h0)
		`CHK(raw_scan, 1'h0)
		@(posedge mclk);
		reset_request_in <= 1'h1;
		#1;
		`CHK(unfiltered_reset_n, 1'h1)
		`CHK(filtered_reset_n, 1'h0)
		`CHK(filt_sync, 1'h1)
		`CHK(raw_sync, 1'h1)
		edges_to(1'h1, n);
		`CHK(n, 6)
		`CHK(filt_sync, 1'h1)
		`CHK(filt_scan, 1'h1)
	endtask

	// Scan inputs are ignored when scan support is off.
	task automatic scan_ignored();
		@(posedge mclk);
		scan_reset_n <= 1'h0;
		scan_mode_sel <= 1'h1;
		repeat (3) @(posedge mclk);
		#1;
		`CHK(filtered_reset_n, 1'h1)
		`CHK(reset_source, RSF_SRC_NORMAL)
		`CHK(filt_scan, 1'h0)
		`CHK(src_scan, RSF_SRC_SCAN)
		`CHK(filt_sync, 1'h1)
		`CHK(src_sync, RSF_SRC_NORMAL)
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		repeat (4) @(posedge mclk);
		reset_n <= 1'h1;
		repeat (4) @(posedge mclk);
		lock_glitch();
		lock_release();
		request_pulse();
		scan_ignored();
		lock_drop();
		stop_test();
	end
endmodule

`default_nettype wire
